// File: design/spi_cfg_regs.svh
// register offsets, field positions and reset values of the spi configuration block
//
// Functional notes
// [R1] Control register two reads zero at bits 7, 6, 5 and 2, and those bits hold no state.
// [R2] In slave operation mode-fault enable is ignored and the select pin is always the select input.
// [R3] In master operation a cleared mode-fault enable releases the select pin to the port, a set one makes it fault input or select output.
// [R4] In single-wire mode the bidirectional output enable sets the shared pin direction, 0 input and 1 output.
// [R5] With single-wire control cleared the bidirectional output enable has no effect at all.
// [R6] In single-wire mode a master shares the MOSI pin and a slave shares the MISO pin.
// [R7] Single-wire pin control at bit 0 selects separate data pins when 0 and one shared data pin when 1.
// [R8] Stop-in-wait at bit 1 keeps the interface clocks running in wait mode when 0 and stops them when 1.
// [R9] The bit-rate register may be read and written at any time whatever the transfer state.
// [R10] The prescale field at bits 6:4 divides the bus clock by its value plus one, 1 through 8.
// [R11] The rate divisor field divides the prescaler output by two to the power of code plus one, 2 through 512.
// [R12] Software must not program a rate divisor code above 1000, those codes are reserved.
// [R13] The prescaler feeds the rate divider, whose output is the master bit clock.
// [R14] In single-wire master operation the MISO pin is unused and returns to the port.
// [R15] In master operation with mode-fault enabled, select output enable 0 gives a fault input and 1 an automatic select output.
// [R16] A new prescale or divisor value takes effect at a byte boundary so a running transfer keeps its rate.
`ifndef SPI_CFG_REGS_SVH
`define SPI_CFG_REGS_SVH

`define SPI_CTRL2_OFFSET 8'h00
`define SPI_BITRATE_OFFSET 8'h04

`define SPI_CTRL2_FAULT_EN_BIT 4
`define SPI_CTRL2_BIDIR_OE_BIT 3
`define SPI_CTRL2_SWAI_BIT 1
`define SPI_CTRL2_SPC_BIT 0
`define SPI_CTRL2_RESET 8'h00

`define SPI_BR_PRESC_LSB 4
`define SPI_BR_PRESC_MSB 6
`define SPI_BR_DIV_LSB 0
`define SPI_BR_DIV_MSB 3
`define SPI_BR_DIV_MAX 4'h8
`define SPI_BR_RESET 8'h00

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: design/spi_cfg_pkg.sv
// types shared by the spi configuration block
package spi_cfg_pkg;

    // pin drive group towards the pads
    typedef struct packed {
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
        logic ss_out;
        logic ss_oe;
    } pin_out_t;

    // hand-off signals from the pin mux towards the shifter side
    typedef struct packed {
        logic serial_in;
        logic ss_n_level;
        logic mode_fault_active;
        logic ss_port_release;
        logic miso_port_release;
    } core_view_t;

    // role of the slave select pin
    typedef enum logic [1:0] {
        SS_SLAVE_IN,
        SS_PORT,
        SS_FAULT_IN,
        SS_AUTO_OUT
    } ss_role_t;

    // one entry of the read response buffer
    typedef struct packed {
        logic [31:0] data;
        logic [1:0] resp;
    } rd_entry_t;

endpackage

// File: design/spi_bit_clock_gen.sv
// prescaler and power-of-two divider that make the master bit clock
`timescale 1ns/100ps
`default_nettype none
`include "spi_cfg_regs.svh"

module spi_bit_clock_gen (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic run,
    input wire logic load,
    input wire logic [2:0] presc_code,
    input wire logic [3:0] div_code,
    output logic sck_level,
    output logic sck_edge
);

    typedef struct packed {
        logic [2:0] presc_act;
        logic [3:0] div_act;
        logic [2:0] pcnt;
        logic [8:0] hcnt;
        logic sck_level;
        logic sck_edge;
    } st_t;

    st_t s;
    st_t n;

    // last count of one half bit period, in prescaler ticks
    function automatic logic [8:0] half_last(input logic [3:0] code);
        half_last = (9'h001 << code) - 9'h001;
    endfunction

    // the divider runs a half period per 2^code ticks, so a full bit is 2^(code+1)
    always_comb begin
        n = s;
        n.sck_edge = 1'b0;
        if (load) begin
            n.presc_act = presc_code; // [R16]
            n.div_act = div_code; // [R16]
        end
        if (!run) begin
            n.pcnt = 3'h0;
            n.hcnt = 9'h000;
            n.sck_level = 1'b0;
        end else if (s.pcnt >= s.presc_act) begin // a count past a lowered end stops now
            n.pcnt = 3'h0; // [R10]
            if (s.hcnt >= half_last(s.div_act)) begin
                n.hcnt = 9'h000; // [R11]
                n.sck_edge = 1'b1; // [R13]
                n.sck_level = ~s.sck_level;
            end else begin
                n.hcnt = s.hcnt + 9'h001;
            end
        end else begin
            n.pcnt = s.pcnt + 3'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s <= '0;
        end else if (clk_en) begin
            s <= n;
        end
    end

    assign sck_level = s.sck_level;
    assign sck_edge = s.sck_edge;

endmodule // spi_bit_clock_gen

`default_nettype wire

// File: design/spi_pin_config.sv
// spi secondary configuration: registers over axi4-lite, pin mux and bit clock
`timescale 1ns/100ps
`default_nettype none
`include "spi_cfg_regs.svh"

module spi_pin_config #(
    parameter int ADDR_W = 8,
    parameter int RBUF_DEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // shifter side
    input wire logic master_select,
    input wire logic slave_select_output_enable,
    input wire logic wait_mode,
    input wire logic byte_boundary,
    input wire logic serial_out,
    input wire logic ss_drive_n,
    output spi_cfg_pkg::core_view_t core_view,
    output logic clocks_run,
    output logic sck_level,
    output logic sck_edge,
    // pads
    input wire logic mosi_in,
    input wire logic miso_in,
    input wire logic ss_in,
    output spi_cfg_pkg::pin_out_t pins
);

    // pointer and count widths of the read buffer
    localparam int PW = (RBUF_DEPTH > 1) ? $clog2(RBUF_DEPTH) : 1;
    localparam int CW = $clog2(RBUF_DEPTH + 1);

    // refuse shapes the decode and the buffer cannot serve
    generate
        if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
            $error("spi_pin_config: ADDR_W must lie in 3..32");
        end
        if (RBUF_DEPTH < 2) begin : g_bad_depth
            $error("spi_pin_config: RBUF_DEPTH must be at least 2");
        end
    endgenerate

    typedef struct packed {
        logic fault_en;
        logic bidir_oe;
        logic swai;
        logic spc;
        logic [2:0] presc;
        logic [3:0] div;

        logic aw_held;
        logic [ADDR_W-1:0] awaddr;
        logic w_held;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;

        spi_cfg_pkg::rd_entry_t [RBUF_DEPTH-1:0] rbuf;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;

        spi_cfg_pkg::pin_out_t pins;
        spi_cfg_pkg::core_view_t view;
        spi_cfg_pkg::ss_role_t ss_role;
    } st_t;

    // state and its next value
    st_t s;
    st_t n;

    // wait gating and buffer strobes
    logic clk_run;
    logic rd_push;
    logic rd_pop;

    // register decode, shared by the read and the write path
    function automatic logic is_ctrl2(input logic [ADDR_W-1:0] a);
        is_ctrl2 = (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPI_CTRL2_OFFSET >> 2));
    endfunction

    function automatic logic is_bitrate(input logic [ADDR_W-1:0] a);
        is_bitrate = (a[ADDR_W-1:2] == (ADDR_W-2)'(`SPI_BITRATE_OFFSET >> 2));
    endfunction

    // wrap a buffer pointer at the depth
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        if (p == PW'(RBUF_DEPTH - 1)) begin
            ptr_inc = '0;
        end else begin
            ptr_inc = p + PW'(1);
        end
    endfunction

    // read data of a register, unimplemented bits are constant zero
    function automatic spi_cfg_pkg::rd_entry_t read_reg(input st_t q, input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        read_reg.resp = `AXI_RESP_OKAY;
        if (is_ctrl2(a)) begin
            v[`SPI_CTRL2_FAULT_EN_BIT] = q.fault_en; // [R1]
            v[`SPI_CTRL2_BIDIR_OE_BIT] = q.bidir_oe;
            v[`SPI_CTRL2_SWAI_BIT] = q.swai;
            v[`SPI_CTRL2_SPC_BIT] = q.spc;
        end else if (is_bitrate(a)) begin
            v[`SPI_BR_PRESC_MSB:`SPI_BR_PRESC_LSB] = q.presc; // [R9]
            v[`SPI_BR_DIV_MSB:`SPI_BR_DIV_LSB] = q.div;
        end else begin
            read_reg.resp = `AXI_RESP_SLVERR;
        end
        read_reg.data = {24'h000000, v};
    endfunction

    // stopping in wait mode freezes the divider; registers stay reachable
    assign clk_run = !(s.swai && wait_mode); // [R8]

    // bus handshakes are combinational from state
    assign s_axi_awready = !s.aw_held && !s.bvalid;
    assign s_axi_wready = !s.w_held && !s.bvalid;

    // a full buffer refuses the address
    assign s_axi_arready = (s.count != CW'(RBUF_DEPTH));

    // one answer in and one out per cycle
    assign rd_push = s_axi_arvalid && s_axi_arready;
    assign rd_pop = s_axi_rvalid && s_axi_rready;

    always_comb begin
        n = s;
        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            n.aw_held = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            n.w_held = 1'b1;
            n.wdata = s_axi_wdata[7:0];
            n.wlane0 = s_axi_wstrb[0];
        end

        // commit once both halves are held; writes go through in any transfer state
        if (s.aw_held && s.w_held && !s.bvalid) begin
            n.aw_held = 1'b0;
            n.w_held = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `AXI_RESP_OKAY;
            // only byte lane 0 carries a register
            if (is_ctrl2(s.awaddr)) begin
                if (s.wlane0) begin
                    n.fault_en = s.wdata[`SPI_CTRL2_FAULT_EN_BIT]; // [R1]
                    n.bidir_oe = s.wdata[`SPI_CTRL2_BIDIR_OE_BIT];
                    n.swai = s.wdata[`SPI_CTRL2_SWAI_BIT];
                    n.spc = s.wdata[`SPI_CTRL2_SPC_BIT];
                end
            end else if (is_bitrate(s.awaddr)) begin
                if (s.wlane0) begin
                    n.presc = s.wdata[`SPI_BR_PRESC_MSB:`SPI_BR_PRESC_LSB]; // [R9]
                    // reserved divisor codes are clamped to the slowest rate
                    if (s.wdata[`SPI_BR_DIV_MSB:`SPI_BR_DIV_LSB] > `SPI_BR_DIV_MAX) begin
                        n.div = `SPI_BR_DIV_MAX; // [R12]
                    end else begin
                        n.div = s.wdata[`SPI_BR_DIV_MSB:`SPI_BR_DIV_LSB];
                    end
                end
            end else begin
                n.bresp = `AXI_RESP_SLVERR;
            end
        end

        // the answer stands until taken
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end

        // read answers queue in the buffer so a stalled rready loses none
        if (rd_push) begin
            n.rbuf[s.wr_ptr] = read_reg(s, s_axi_araddr);
            n.wr_ptr = ptr_inc(s.wr_ptr);
        end
        if (rd_pop) begin
            n.rd_ptr = ptr_inc(s.rd_ptr);
        end

        // the count tells full from empty
        if (rd_push && !rd_pop) begin
            n.count = s.count + CW'(1);
        end else if (rd_pop && !rd_push) begin
            n.count = s.count - CW'(1);
        end

        // select pin role from master select, fault enable and output enable
        // recomputed every cycle, no write needed
        if (!master_select) begin
            n.ss_role = spi_cfg_pkg::SS_SLAVE_IN; // [R2]
        end else if (!s.fault_en) begin
            n.ss_role = spi_cfg_pkg::SS_PORT; // [R3]
        end else if (!slave_select_output_enable) begin
            n.ss_role = spi_cfg_pkg::SS_FAULT_IN; // [R15]
        end else begin
            n.ss_role = spi_cfg_pkg::SS_AUTO_OUT; // [R15]
        end

        // default: every pad released, nothing driven
        n.pins = '0;
        n.view.ss_n_level = ss_in;
        n.view.ss_port_release = (n.ss_role == spi_cfg_pkg::SS_PORT); // [R3]
        n.view.mode_fault_active = (n.ss_role == spi_cfg_pkg::SS_FAULT_IN); // [R15]
        n.view.miso_port_release = 1'b0;

        // only an automatic select output drives it
        if (n.ss_role == spi_cfg_pkg::SS_AUTO_OUT) begin
            n.pins.ss_out = ss_drive_n; // [R15]
            n.pins.ss_oe = 1'b1;
        end

        // data pins; bidir_oe is looked at only under single-wire mode
        if (master_select) begin
            n.pins.mosi_out = serial_out;
            if (s.spc) begin
                n.pins.mosi_oe = s.bidir_oe; // [R4] [R6]
                n.view.serial_in = mosi_in; // [R6]
                n.view.miso_port_release = 1'b1; // [R14]
            end else begin
                n.pins.mosi_oe = 1'b1; // [R7] [R5]
                n.view.serial_in = miso_in; // [R7]
            end
        end else begin
            // a slave drives its output only while selected, to share the line
            n.pins.miso_out = serial_out;
            n.view.serial_in = s.spc ? miso_in : mosi_in; // [R6] [R7]
            if (s.spc) begin
                n.pins.miso_oe = s.bidir_oe && !ss_in; // [R4] [R6]
            end else begin
                n.pins.miso_oe = !ss_in; // [R5] [R7]
            end
        end
    end

    // single state register; clk_en freezes everything
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // register fields take their reset values
            s <= '0;
            s.fault_en <= 1'(`SPI_CTRL2_RESET >> `SPI_CTRL2_FAULT_EN_BIT);
            s.presc <= 3'(`SPI_BR_RESET >> `SPI_BR_PRESC_LSB);
            s.div <= 4'(`SPI_BR_RESET >> `SPI_BR_DIV_LSB);
            s.ss_role <= spi_cfg_pkg::SS_SLAVE_IN;
        end else if (clk_en) begin
            s <= n;
        end
    end

    // prescaler then divider; new rates load only at byte boundaries
    spi_bit_clock_gen u_bit_clock_gen (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clk_en(clk_en && clk_run), // [R8]
        .run(master_select),
        .load(byte_boundary), // [R16]
        .presc_code(s.presc),
        .div_code(s.div),
        .sck_level(sck_level),
        .sck_edge(sck_edge)
    );

    // bus answers straight from flops
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_rvalid = (s.count != '0);
    assign s_axi_rdata = s.rbuf[s.rd_ptr].data;
    assign s_axi_rresp = s.rbuf[s.rd_ptr].resp;

    // pads and view lag inputs a cycle
    assign pins = s.pins;
    assign core_view = s.view;

    // comb, so the shifter stops with the divider
    assign clocks_run = clk_run;

endmodule // spi_pin_config

`default_nettype wire

// File: verification/spi_far_peer.sv
// far side peer that answers on the data and select pads
`timescale 1ns/100ps
`default_nettype none
module spi_far_peer (
    input wire logic clk_sys,
    input wire logic sck_level,
    input wire logic sel_n,
    input wire spi_cfg_pkg::pin_out_t pins,
    output logic mosi_in,
    output logic miso_in,
    output logic ss_in
);
    logic [7:0] shift_reg = 8'hA5;
    logic idle_reg = 1'h0;

    // a released MOSI line, or MISO while deselected, toggles every cycle so a stale level never passes for data
    always @(posedge clk_sys) begin
        idle_reg <= ~idle_reg;
    end

    // reply bits advance on each rising bit clock
    always @(posedge sck_level) begin
        shift_reg <= {shift_reg[6:0], shift_reg[7]};
    end

    // a pad the block drives shows the block's level, otherwise the peer's
    assign mosi_in = pins.mosi_oe ? pins.mosi_out : idle_reg;
    assign miso_in = pins.miso_oe ? pins.miso_out : (sel_n ? idle_reg : shift_reg[7]);
    assign ss_in = pins.ss_oe ? pins.ss_out : sel_n;
endmodule // spi_far_peer
`default_nettype wire

// File: verification/spi_pin_config_monitor.sv
// concurrent checks on the ports of the spi pin configuration block
`timescale 1ns/100ps
`default_nettype none
module spi_pin_config_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic master_select,
    input wire logic wait_mode,
    input wire spi_cfg_pkg::core_view_t core_view,
    input wire logic clocks_run,
    input wire logic sck_level,
    input wire spi_cfg_pkg::pin_out_t pins
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // bus answers stand until taken, and a write answer needs two edges
    AST_B_HOLD: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer withdrawn");
    AST_R_HOLD: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer withdrawn");
    AST_W_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_W_LAT: assert property (
        clk_en && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready ##1 clk_en
        |=> s_axi_bvalid) else $error("write answer late");
    AST_R_LAT: assert property (
        clk_en && s_axi_arvalid && s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid)
        else $error("read answer late");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read data above byte lane");
    // wait gating, the bit clock and the pin roles that master selection fixes
    AST_WAIT_RUN: assert property (!wait_mode |-> clocks_run)
        else $error("clocks stopped outside wait");
    AST_SCK_SLAVE: assert property (clk_en && clocks_run && !master_select |=> !sck_level)
        else $error("bit clock running in slave mode");
    AST_SS_SLAVE: assert property (
        clk_en && !master_select |=> !pins.ss_oe && !core_view.mode_fault_active)
        else $error("select pin not an input in slave mode");
    AST_MOSI_SLAVE: assert property (clk_en && !master_select |=> !pins.mosi_oe)
        else $error("slave drives master data pin");
    AST_MISO_MASTER: assert property (clk_en && master_select |=> !pins.miso_oe)
        else $error("master drives slave data pin");
endmodule // spi_pin_config_monitor

bind spi_pin_config spi_pin_config_monitor i_spi_pin_config_monitor (
    .clk_sys, .rst_n, .clk_en, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .master_select, .wait_mode, .core_view, .clocks_run,
    .sck_level, .pins);
`default_nettype wire

// File: verification/spi_pin_config_and_baud_rate_tb_top.sv
// self-checking bench for the spi pin configuration and bit rate block
`timescale 1ns/100ps
`default_nettype none
`include "spi_cfg_regs.svh"
module spi_pin_config_and_baud_rate_tb_top;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic clk_en = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic master_select = 1'h0;
    logic slave_select_output_enable = 1'h0;
    logic wait_mode = 1'h0;
    logic byte_boundary = 1'h1;
    logic serial_out = 1'h0;
    logic ss_drive_n = 1'h1;
    logic sel_n = 1'h1;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic clocks_run, sck_level, sck_edge, mosi_in, miso_in, ss_in;
    spi_cfg_pkg::core_view_t core_view;
    spi_cfg_pkg::pin_out_t pins;
    int errors = 0;
    int checks = 0;

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    spi_pin_config i_spi_pin_config (.clk_sys, .rst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_select,
        .slave_select_output_enable, .wait_mode, .byte_boundary, .serial_out, .ss_drive_n,
        .core_view, .clocks_run, .sck_level, .sck_edge, .mosi_in, .miso_in, .ss_in, .pins);
    spi_far_peer i_spi_far_peer (.clk_sys, .sck_level, .sel_n, .pins, .mosi_in, .miso_in,
        .ss_in);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ready is judged at the negedge before the edge, which sees the same settled level
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            output logic [1:0] r);
        logic ta, tw, tb;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end while (!tb);
        s_axi_bready <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        logic [31:0] d;
        logic [1:0] r;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'h0;
        end while (!tr);
        s_axi_rready <= 1'h0;
        @(posedge clk_sys);
        chk("read data", e, d);
        chk("read resp", {30'h0, er}, {30'h0, r});
    endtask

    // reset values, unused bits, reserved divisor, empty strobe and an unmapped place
    task automatic t_regs;
        logic [1:0] r;
        rchk(`SPI_CTRL2_OFFSET, 32'h0, `AXI_RESP_OKAY);
        rchk(`SPI_BITRATE_OFFSET, 32'h0, `AXI_RESP_OKAY);
        wr(`SPI_CTRL2_OFFSET, 32'hFF, 4'hF, r);
        rchk(`SPI_CTRL2_OFFSET, 32'h1B, `AXI_RESP_OKAY);
        wr(`SPI_BITRATE_OFFSET, 32'hFF, 4'hF, r);
        rchk(`SPI_BITRATE_OFFSET, 32'h78, `AXI_RESP_OKAY);
        wr(`SPI_CTRL2_OFFSET, 32'h00, 4'h0, r);
        rchk(`SPI_CTRL2_OFFSET, 32'h1B, `AXI_RESP_OKAY);
        wr(8'h08, 32'hFF, 4'hF, r);
        chk("unmapped write", {30'h0, `AXI_RESP_SLVERR}, {30'h0, r});
        rchk(8'h08, 32'h0, `AXI_RESP_SLVERR);
    endtask

    // roles of the data and select pins for ten combinations of mode and control setting
    task automatic t_pins;
        logic [15:0] tab [10] = '{16'h8022, 16'h8424, 16'hC428, 16'h8263, 16'h8043,
            16'h0010, 16'h4410, 16'h0040, 16'h0250, 16'h8222};
        logic [1:0] r;
        sel_n <= 1'h0;
        serial_out <= 1'h1;
        foreach (tab[i]) begin
            master_select <= tab[i][15];
            slave_select_output_enable <= tab[i][14];
            wr(`SPI_CTRL2_OFFSET, {24'h0, tab[i][13:6]}, 4'h1, r);
            repeat (3) @(posedge clk_sys);
            @(negedge clk_sys);
            chk("pin roles", {26'h0, tab[i][5:0]}, {26'h0, pins.mosi_oe, pins.miso_oe,
                pins.ss_oe, core_view.mode_fault_active, core_view.ss_port_release,
                core_view.miso_port_release});
            chk("data out", {30'h0, tab[i][15], !tab[i][15]},
                {30'h0, pins.mosi_out, pins.miso_out});
            chk("select", {30'h0, tab[i][3], tab[i][3]},
                {30'h0, pins.ss_out, core_view.ss_n_level});
            @(posedge clk_sys);
        end
        sel_n <= 1'h1;
        serial_out <= 1'h0;
    endtask

    task automatic t_wait;
        logic [1:0] r;
        wait_mode <= 1'h1;
        wr(`SPI_CTRL2_OFFSET, 32'h00, 4'h1, r);
        @(negedge clk_sys);
        chk("clocks run", 32'h1, {31'h0, clocks_run});
        @(posedge clk_sys);
        wr(`SPI_CTRL2_OFFSET, 32'h02, 4'h1, r);
        @(negedge clk_sys);
        chk("clocks stopped", 32'h0, {31'h0, clocks_run});
        @(posedge clk_sys);
        wait_mode <= 1'h0;
    endtask

    // fill the read buffer while stalled, then drain it with a request still waiting
    task automatic t_buf;
        int na = 0;
        int nr = 0;
        s_axi_araddr <= `SPI_BITRATE_OFFSET;
        s_axi_arvalid <= 1'h1;
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            na += s_axi_arvalid & s_axi_arready;
            nr += s_axi_rvalid & s_axi_rready;
            if (i == 5) chk("reads taken while stalled", 32'h2, na);
            @(posedge clk_sys);
            if (na == 3) s_axi_arvalid <= 1'h0;
            s_axi_rready <= (i >= 5);
        end
        chk("answers drained", 32'h3, nr);
        @(posedge clk_sys);
        s_axi_rready <= 1'h0;
    endtask

    task automatic half_period(output int n);
        n = 0;
        do @(negedge clk_sys); while (!sck_edge);
        do begin
            @(negedge clk_sys);
            n++;
        end while (!sck_edge);
        @(posedge clk_sys);
    endtask

    // half bit period for a spread of codes, then a change held back mid byte
    task automatic t_rate;
        logic [6:0] codes [4] = '{7'h00, 7'h21, 7'h43, 7'h78}; // legal codes only
        logic [1:0] r;
        int n;
        master_select <= 1'h1;
        foreach (codes[i]) begin
            wr(`SPI_BITRATE_OFFSET, {25'h0, codes[i]}, 4'hF, r);
            repeat (3) half_period(n);
            chk("half bit period", (codes[i][6:4] + 1) << codes[i][3:0], n);
        end
        byte_boundary <= 1'h0;
        wr(`SPI_BITRATE_OFFSET, 32'h00, 4'hF, r);
        rchk(`SPI_BITRATE_OFFSET, 32'h00, `AXI_RESP_OKAY);
        repeat (2) half_period(n);
        chk("rate held mid byte", 32'h800, n);
        byte_boundary <= 1'h1;
        repeat (3) half_period(n);
        chk("rate after boundary", 32'h1, n);
        master_select <= 1'h0;
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'h1;
        t_regs;
        t_pins;
        t_wait;
        t_buf;
        t_rate;
        results;
    end

    // the run needs about 22000 cycles, so 40000 means a hung handshake
    initial begin
        #400000;
        errors++;
        results;
    end
endmodule // spi_pin_config_and_baud_rate_tb_top
`default_nettype wire
